// file: cwgas_top.v
// Auto-shutdown source selection, dead-band generation and register slave
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "cwgas_consts.vh"
module cwgas_top #(
  parameter DB_W = 6
) (
  // Clock and reset
  input wire mclk_in,
  input wire reset_n_in,
  // Avalon-MM slave
  input wire [2:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Shutdown sources
  input wire fault_input_in,
  input wire comparator_one_in,
  input wire logic_cell_two_output_in,
  // Waveform input
  input wire waveform_in,
  // Complementary outputs
  output reg out_a_out,
  output reg out_a_oe_out,
  output reg out_b_out,
  output reg out_b_oe_out,
  // Interrupt
  output wire irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg shutdown_event_status;
  reg auto_restart_enable;
  reg comparator_shutdown_enable;
  reg fault_pin_shutdown_enable;
  reg logic_cell_shutdown_enable;
  reg [DB_W-1:0] rising_deadband_count;
  reg [DB_W-1:0] falling_deadband_count;
  reg [1:0] output_a_shutdown_state;
  reg [1:0] output_b_shutdown_state;
  reg [`CWGAS_IRQ_W-1:0] irq_status;
  reg [`CWGAS_IRQ_W-1:0] irq_enable;
  reg rd_done;
  wire sd_source;
  wire wr_ctrl2;
  wire [`CWGAS_IRQ_W-1:0] irq_events;
  wire rise_dly;
  wire fall_dly;
  wire [7:0] ctrl2_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown source combination
  assign sd_source = (fault_pin_shutdown_enable & ~fault_input_in)
    | (logic_cell_shutdown_enable & logic_cell_two_output_in)
    | (comparator_shutdown_enable & comparator_one_in);

  assign wr_ctrl2 = avs_write_in && (avs_address_in == `CWGAS_OFF_CTRL2);
  // Restart fires when status drops while sources have gone
  assign irq_events[`CWGAS_IRQ_SHUTDOWN] = sd_source & ~shutdown_event_status;
  assign irq_events[`CWGAS_IRQ_RESTART] = shutdown_event_status & ~sd_source &
    (auto_restart_enable | (wr_ctrl2 & ~avs_writedata_in[`CWGAS_BIT_STATUS]));

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and shutdown status
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shutdown_event_status <= 1'b0;
      auto_restart_enable <= 1'b0;
      comparator_shutdown_enable <= 1'b0;
      fault_pin_shutdown_enable <= 1'b0;
      logic_cell_shutdown_enable <= 1'b0;
      rising_deadband_count <= {DB_W{1'b0}};
      falling_deadband_count <= {DB_W{1'b0}};
      output_a_shutdown_state <= `CWGAS_SD_INACTIVE;
      output_b_shutdown_state <= `CWGAS_SD_INACTIVE;
      irq_status <= {`CWGAS_IRQ_W{1'b0}};
      irq_enable <= {`CWGAS_IRQ_W{1'b0}};
    end else begin
      // A live source always wins over a software clear or restart
      if (sd_source) begin
        shutdown_event_status <= 1'b1;
      end else if (auto_restart_enable) begin
        shutdown_event_status <= 1'b0;
      end else if (wr_ctrl2) begin
        shutdown_event_status <= avs_writedata_in[`CWGAS_BIT_STATUS];
      end
      if (wr_ctrl2) begin
        auto_restart_enable <= avs_writedata_in[`CWGAS_BIT_RESTART];
        comparator_shutdown_enable <= avs_writedata_in[`CWGAS_BIT_CMP];
        fault_pin_shutdown_enable <= avs_writedata_in[`CWGAS_BIT_FLT];
        logic_cell_shutdown_enable <= avs_writedata_in[`CWGAS_BIT_LC2];
      end
      if (avs_write_in && avs_address_in == `CWGAS_OFF_RISE) begin
        rising_deadband_count <= avs_writedata_in[DB_W-1:0];
      end
      if (avs_write_in && avs_address_in == `CWGAS_OFF_FALL) begin
        falling_deadband_count <= avs_writedata_in[DB_W-1:0];
      end
      if (avs_write_in && avs_address_in == `CWGAS_OFF_STATES) begin
        output_a_shutdown_state <= avs_writedata_in[`CWGAS_ST_A_LO+1:`CWGAS_ST_A_LO];
        output_b_shutdown_state <= avs_writedata_in[`CWGAS_ST_B_LO+1:`CWGAS_ST_B_LO];
      end
      if (avs_write_in && avs_address_in == `CWGAS_OFF_IRQ_EN) begin
        irq_enable <= avs_writedata_in[`CWGAS_IRQ_W-1:0];
      end
      // Set wins over clear in the same cycle
      if (avs_write_in && avs_address_in == `CWGAS_OFF_IRQ_CLR) begin
        irq_status <= (irq_status & ~avs_writedata_in[`CWGAS_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  assign irq_out = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon read path: one wait cycle on reads, writes take zero
  assign avs_waitrequest_out = avs_read_in & ~rd_done;
  assign ctrl2_rd = {shutdown_event_status, auto_restart_enable, 3'h0,
    comparator_shutdown_enable, fault_pin_shutdown_enable, logic_cell_shutdown_enable};

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_done <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      rd_done <= avs_read_in & ~rd_done;
      if (avs_read_in && !rd_done) begin
        case (avs_address_in)
          `CWGAS_OFF_CTRL2: avs_readdata_out <= {24'h00_0000, ctrl2_rd};
          `CWGAS_OFF_RISE: avs_readdata_out <= {26'h000_0000, rising_deadband_count};
          `CWGAS_OFF_FALL: avs_readdata_out <= {26'h000_0000, falling_deadband_count};
          `CWGAS_OFF_STATES: avs_readdata_out <= {28'h000_0000,
            output_b_shutdown_state, output_a_shutdown_state};
          `CWGAS_OFF_IRQ_STAT: avs_readdata_out <= {30'h0000_0000, irq_status};
          `CWGAS_OFF_IRQ_EN: avs_readdata_out <= {30'h0000_0000, irq_enable};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead-band channels: A delays the rising edge, B the falling edge
  cwgas_deadband #(
    .W(DB_W)
  ) u_rise (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .count_in(rising_deadband_count),
    .src_in(waveform_in),
    .dly_out(rise_dly)
  );

  cwgas_deadband #(
    .W(DB_W)
  ) u_fall (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .count_in(falling_deadband_count),
    .src_in(~waveform_in),
    .dly_out(fall_dly)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage with shutdown override
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_a_out <= 1'b0;
      out_a_oe_out <= 1'b1;
      out_b_out <= 1'b0;
      out_b_oe_out <= 1'b1;
    end else if (shutdown_event_status) begin
      out_a_oe_out <= (output_a_shutdown_state != `CWGAS_SD_TRISTATE);
      out_a_out <= (output_a_shutdown_state == `CWGAS_SD_HIGH);
      out_b_oe_out <= (output_b_shutdown_state != `CWGAS_SD_TRISTATE);
      out_b_out <= (output_b_shutdown_state == `CWGAS_SD_HIGH);
    end else begin
      out_a_oe_out <= 1'b1;
      out_a_out <= rise_dly;
      out_b_oe_out <= 1'b1;
      out_b_out <= fall_dly;
    end
  end
endmodule // cwgas_top

// file: cwgas_consts.vh
// Constants for the auto-shutdown and dead-band block
//
// Contract
// - With the fault-pin shutdown enable (bit 1) set, a low fault input raises a shutdown event.
// - With the fault-pin shutdown enable clear, the fault input is ignored for shutdown.
// - With the logic-cell shutdown enable (bit 0) set, a high logic cell 2 output raises shutdown.
// - The rising dead band is a 6-bit unsigned count in bits 5..0 of the rising count register.
// - A nonzero count N inserts a dead band of N to N+1 count-clock periods.
// - A rising count of zero inserts no delay on the rising transition.
// - Bits 7..6 of the rising count register are unimplemented and read as zero.
// - While the shutdown status bit is 1, each output takes its selected shutdown state.
// - The falling dead band uses the same 6-bit encoding, and zero bypasses it.
`ifndef CWGAS_CONSTS_VH
`define CWGAS_CONSTS_VH
////////////////////////////////////////////////////////////////////////////////
// Register word offsets (byte address = 4 * offset)
`define CWGAS_OFF_CTRL2 3'h0
`define CWGAS_OFF_RISE 3'h1
`define CWGAS_OFF_FALL 3'h2
`define CWGAS_OFF_STATES 3'h3
`define CWGAS_OFF_IRQ_STAT 3'h4
`define CWGAS_OFF_IRQ_EN 3'h5
`define CWGAS_OFF_IRQ_CLR 3'h6
////////////////////////////////////////////////////////////////////////////////
// Shutdown control fields
`define CWGAS_BIT_STATUS 7
`define CWGAS_BIT_RESTART 6
`define CWGAS_BIT_CMP 2
`define CWGAS_BIT_FLT 1
`define CWGAS_BIT_LC2 0
`define CWGAS_CTRL2_RESET 8'h00
`define CWGAS_DB_W 6
`define CWGAS_DB_ZERO 6'h00
// Shutdown state register layout: b in 3..2, a in 1..0
`define CWGAS_ST_A_LO 0
`define CWGAS_ST_B_LO 2
`define CWGAS_STATES_RESET 4'h0
// Shutdown state encodings
`define CWGAS_SD_INACTIVE 2'h0
`define CWGAS_SD_TRISTATE 2'h1
`define CWGAS_SD_LOW 2'h2
`define CWGAS_SD_HIGH 2'h3
// Interrupt bits
`define CWGAS_IRQ_SHUTDOWN 0
`define CWGAS_IRQ_RESTART 1
`define CWGAS_IRQ_W 2
`endif

// file: cwgas_deadband.v
// One dead-band delay channel: delays the rising edge of its input by a count
`timescale 1ns/1ps
module cwgas_deadband #(
  parameter W = 6
) (
  // Clock and reset
  input wire mclk_in,
  input wire reset_n_in,
  // Control
  input wire [W-1:0] count_in,
  input wire src_in,
  // Result
  output reg dly_out
);
  reg [W-1:0] cnt;
  reg src_q;
  wire [W-1:0] zero_w = {W{1'b0}};

  // Counting starts at the first edge after the source rises, so N..N+1
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt <= {W{1'b0}};
      src_q <= 1'b0;
      dly_out <= 1'b0;
    end else begin
      src_q <= src_in;
      if (!src_in) begin
        cnt <= zero_w;
        dly_out <= 1'b0;
      end else if (count_in == zero_w) begin
        dly_out <= 1'b1;
      end else if (!src_q) begin
        cnt <= count_in - {{(W-1){1'b0}}, 1'b1};
        dly_out <= 1'b0;
      end else if (cnt != zero_w) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end else begin
        dly_out <= 1'b1;
      end
    end
  end
endmodule // cwgas_deadband

// file: cwgas_top_asserts.sv
// Port checker for the shutdown and dead-band block
`timescale 1ns/1ps
module cwgas_top_asserts #(parameter DB_W = 6) (
  input wire mclk_in, input wire reset_n_in, input wire [2:0] avs_address_in,
  input wire avs_read_in, input wire avs_write_in, input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out, input wire avs_waitrequest_out,
  input wire fault_input_in, input wire comparator_one_in, input wire logic_cell_two_output_in,
  input wire waveform_in, input wire out_a_out, input wire out_a_oe_out, input wire out_b_out,
  input wire out_b_oe_out, input wire irq_out
);
  reg [2:0] en;
  reg [3:0] st;
  reg [5:0] rise;
  reg [5:0] fall;
  reg [1:0] ien;
  reg [7:0] hi_n;
  reg [7:0] lo_n;
  reg [7:0] calm;
  wire wr = avs_write_in & ~avs_waitrequest_out;
  wire src = (en[1] & ~fault_input_in) | (en[0] & logic_cell_two_output_in)
    | (en[2] & comparator_one_in);
  // Edge counts only trusted long after any shutdown or control write
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {en, st, rise, fall, ien, hi_n, lo_n} <= 37'h0;
      calm <= 8'hff;
    end else begin
      if (wr && avs_address_in == 3'h0) en <= avs_writedata_in[2:0];
      if (wr && avs_address_in == 3'h1) rise <= avs_writedata_in[5:0];
      if (wr && avs_address_in == 3'h2) fall <= avs_writedata_in[5:0];
      if (wr && avs_address_in == 3'h3) st <= avs_writedata_in[3:0];
      if (wr && avs_address_in == 3'h5) ien <= avs_writedata_in[1:0];
      hi_n <= waveform_in ? hi_n + {7'h0, hi_n != 8'hff} : 8'h00;
      lo_n <= waveform_in ? 8'h00 : lo_n + {7'h0, lo_n != 8'hff};
      calm <= (src || (wr && avs_address_in == 3'h0)) ? 8'h00 : calm + {7'h0, calm != 8'hff};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rd_wait; $rose(avs_read_in) |-> avs_waitrequest_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answered without wait");
  property p_rd_done; avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read wait too long");
  property p_wr_nowait; avs_write_in |-> !avs_waitrequest_out; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_sd_a; src |-> ##2 (out_a_oe_out == (st[1:0] != 2'h1))
    && (st[1:0] == 2'h1 || out_a_out == (st[1:0] == 2'h3)); endproperty
  a_sd_a: assert property (p_sd_a) else $error("output a shutdown state");
  property p_sd_b; src |-> ##2 (out_b_oe_out == (st[3:2] != 2'h1))
    && (st[3:2] == 2'h1 || out_b_out == (st[3:2] == 2'h3)); endproperty
  a_sd_b: assert property (p_sd_b) else $error("output b shutdown state");
  property p_rise_a; $rose(out_a_out) && calm == 8'hff |-> hi_n == {2'h0, rise} + 8'h02; endproperty
  a_rise_a: assert property (p_rise_a) else $error("rising dead band length");
  property p_rise_b; $rose(out_b_out) && calm == 8'hff |-> lo_n == {2'h0, fall} + 8'h02; endproperty
  a_rise_b: assert property (p_rise_b) else $error("falling dead band length");
  property p_fall_a; $fell(waveform_in) && st[1:0] == 2'h0 |-> ##2 !out_a_out; endproperty
  a_fall_a: assert property (p_fall_a) else $error("output a late to drop");
  property p_irq_off; ien == 2'h0 |-> !irq_out; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");
endmodule // cwgas_top_asserts
bind cwgas_top cwgas_top_asserts #(.DB_W(DB_W)) cwgas_top_asserts_i (.*);

// file: cwgas_stage_model.sv
// Power stage model: pin levels and overlap watch
`timescale 1ns/1ps
module cwgas_stage_model (
  input wire mclk_in, input wire a_in, input wire a_oe_in, input wire b_in, input wire b_oe_in,
  output reg pin_a_out, output reg pin_b_out, output reg [7:0] overlap_out
);
  initial {pin_a_out, pin_b_out, overlap_out} = 10'h0;
  // Undriven pins float: show the inverse, never a stale level
  always @(posedge mclk_in) begin
    pin_a_out <= a_oe_in ? a_in : ~pin_a_out;
    pin_b_out <= b_oe_in ? b_in : ~pin_b_out;
    if (a_oe_in && b_oe_in && a_in && b_in) overlap_out <= overlap_out + 8'h01;
  end
endmodule // cwgas_stage_model

// file: cwg_auto_shutdown_deadband_tb.sv
// Self-checking bench for the shutdown and dead-band block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cwg_auto_shutdown_deadband_tb;
  reg mclk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg [2:0] avs_address_in = 3'h0;
  reg avs_read_in = 1'b0;
  reg avs_write_in = 1'b0;
  reg [31:0] avs_writedata_in = 32'h0;
  reg fault_input_in = 1'b1;
  reg comparator_one_in = 1'b0;
  reg logic_cell_two_output_in = 1'b0;
  reg waveform_in = 1'b0;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, out_a_out, out_a_oe_out, out_b_out, out_b_oe_out, irq_out;
  wire pin_a, pin_b;
  wire [7:0] overlap;
  integer num_errors = 0, compares = 0, k, s;
  reg [31:0] q;
  reg [3:0] st;
  cwgas_top #(.DB_W(6)) cwgas_top_i (.*);
  cwgas_stage_model cwgas_stage_model_i (.mclk_in(mclk_in), .a_in(out_a_out),
    .a_oe_in(out_a_oe_out), .b_in(out_b_out), .b_oe_in(out_b_oe_out),
    .pin_a_out(pin_a), .pin_b_out(pin_b), .overlap_out(overlap));
  //////////////////////////////////////////////////////////////////////////////
  task conclude; begin
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  end endtask
  // Answer taken at the rising edge where waitrequest is seen low
  task bus(input [2:0] a, input w, input [31:0] d); reg done; begin
    avs_address_in <= a; avs_writedata_in <= d; avs_write_in <= w; avs_read_in <= !w;
    done = 1'b0; k = 0;
    while (!done) begin
      @(posedge mclk_in); k = k + 1;
      done = (avs_waitrequest_out === 1'b0); q = avs_readdata_out;
      if (!done && k > 50) begin num_errors++; conclude; end
    end
    avs_write_in <= 1'b0; avs_read_in <= 1'b0; @(posedge mclk_in);
  end endtask
  task chkrd(input [2:0] a, input [31:0] e); begin bus(a, 1'b0, 32'h0); `CHK(q, e) end endtask
  task chkirq(input e); begin @(negedge mclk_in); `CHK(irq_out, e) @(posedge mclk_in); end endtask
  task drive_src(input integer n, input on); begin
    logic_cell_two_output_in <= on && n == 0; fault_input_in <= !(on && n == 1);
    comparator_one_in <= on && n == 2;
  end endtask
  task cnt(input b); begin
    k = 0;
    while ((b ? out_b_out : out_a_out) !== 1'b1 && k < 80) begin
      @(posedge mclk_in); k = k + 1; @(negedge mclk_in); end
    if (k == 80) begin num_errors++; conclude; end
  end endtask
  task pulse(input [5:0] n); begin
    bus(3'h1, 1'b1, {26'h0, n}); bus(3'h2, 1'b1, {26'h0, n});
    waveform_in <= 1'b1; cnt(1'b0);
    `CHK(k, n + 2)
    `CHK(out_b_out, 1'b0)
    @(posedge mclk_in); waveform_in <= 1'b0; cnt(1'b1);
    `CHK(k, n + 2)
    `CHK(out_a_out, 1'b0)
    @(posedge mclk_in);
  end endtask
  //////////////////////////////////////////////////////////////////////////////
  initial forever #5 mclk_in = ~mclk_in;
  initial begin #1000000; num_errors++; conclude; end
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1; @(posedge mclk_in);
    chkrd(3'h0, 32'h0); chkrd(3'h1, 32'h0);
    bus(3'h1, 1'b1, 32'hff); chkrd(3'h1, 32'h3f);
    bus(3'h2, 1'b1, 32'hff); chkrd(3'h2, 32'h3f);
    bus(3'h7, 1'b1, 32'hff); chkrd(3'h7, 32'h0);
    pulse(6'h00); pulse(6'h01); pulse(6'h3f);
    for (s = 0; s < 3; s = s + 1) begin
      st = (s == 0) ? 4'hd : (s == 1) ? 4'h2 : 4'hb;
      bus(3'h3, 1'b1, {28'h0, st}); drive_src(s, 1'b1); repeat (4) @(posedge mclk_in);
      chkrd(3'h0, 32'h0);
      bus(3'h0, 1'b1, 32'h1 << s); repeat (3) @(posedge mclk_in);
      chkrd(3'h0, 32'h80 | (32'h1 << s));
      @(negedge mclk_in);
      `CHK({out_b_oe_out, out_a_oe_out}, {st[3:2] != 2'h1, st[1:0] != 2'h1})
      `CHK({out_b_out & out_b_oe_out, out_a_out & out_a_oe_out}, {st[3:2] == 2'h3, st[1:0] == 2'h3})
      `CHK(pin_b, st[3:2] == 2'h3)
      @(posedge mclk_in); drive_src(s, 1'b0); bus(3'h0, 1'b1, 32'h0);
    end
    bus(3'h6, 1'b1, 32'h3); bus(3'h5, 1'b1, 32'h0); bus(3'h0, 1'b1, 32'h42);
    drive_src(1, 1'b1); repeat (4) @(posedge mclk_in);
    drive_src(1, 1'b0); repeat (4) @(posedge mclk_in);
    chkrd(3'h0, 32'h42);
    chkirq(1'b0); chkrd(3'h4, 32'h3);
    bus(3'h5, 1'b1, 32'h1); chkirq(1'b1);
    bus(3'h6, 1'b1, 32'h1); chkirq(1'b0);
    chkrd(3'h4, 32'h2); chkrd(3'h6, 32'h0);
    `CHK(overlap, 8'h00)
    conclude;
  end
endmodule // cwg_auto_shutdown_deadband_tb
